// File: rtl/act_ctrl.sv
// Configuration, reference selection and interrupt control of the converter.
module act_ctrl
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic trigger,
  input wire logic compare_match,
  input wire logic core_done,
  output logic core_start,
  output logic [4:0] core_channel,
  output logic [3:0] result_bits,
  output logic pos_ref_supply,
  output logic pos_ref_ext,
  output logic pos_ref_bandgap,
  output logic neg_ref_ext,
  output logic irq
);
  logic [15:0] ctrl1;
  logic [15:0] ctrl2;
  logic [15:0] timing;
  logic [15:0] thresh;
  logic [15:0] scan;
  logic [15:0] next_ctrl1;
  logic [15:0] next_ctrl2;
  logic [15:0] next_timing;
  logic [15:0] next_thresh;
  logic [15:0] next_scan;
  logic [15:0] next_rdata;
  logic flag;
  logic next_flag;
  logic matched;
  logic next_matched;
  logic half;
  logic next_half;
  logic [4:0] count;
  logic [4:0] next_count;
  logic trig_s1;
  logic trig_s2;
  logic trig_s3;
  logic match_s1;
  logic match_s2;
  logic converter_on;
  logic threshold_detect_enable;
  act_pkg::act_tim_t threshold_irq_mode;
  logic [4:0] samples_per_irq;
  logic [1:0] pos_ref_select;
  logic neg_ref_select;
  logic irq_event;
  logic clear_flag;
  act_pkg::act_state_t state;
  act_pkg::act_state_t next_state;
  act_core_if cif ();

  act_seq u_seq
  (
    .clk(clk),
    .rstn(rstn),
    .cif(cif),
    .scan_mask(scan),
    .core_done_pin(core_done),
    .core_start(core_start),
    .core_channel(core_channel)
  );

  assign converter_on = ctrl1[act_pkg::CTRL1_ON];
  assign threshold_detect_enable = thresh[act_pkg::THR_EN];
  assign threshold_irq_mode = act_pkg::act_tim_t'(thresh[act_pkg::THR_MODE_LSB +: 2]);
  assign samples_per_irq = ctrl2[act_pkg::CTRL2_SAMPLES_PER_IRQ_LSB +: 5];
  assign pos_ref_select = ctrl2[act_pkg::CTRL2_PREF_LSB +: 2];
  assign neg_ref_select = ctrl2[act_pkg::CTRL2_NREF];
  // The result width follows the resolution choice.
  assign result_bits = ctrl1[act_pkg::CTRL1_RES] ? 4'(act_pkg::RES_HI) : 4'(act_pkg::RES_LO);
  assign pos_ref_supply = pos_ref_select == act_pkg::PREF_SUPPLY;
  assign pos_ref_ext = pos_ref_select == act_pkg::PREF_EXT;
  assign pos_ref_bandgap = pos_ref_select == act_pkg::PREF_BANDGAP;
  assign neg_ref_ext = neg_ref_select;
  // Channel selection never masks shared reference pins, so they stay convertible.

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      match_s1 <= 1'b0;
      match_s2 <= 1'b0;
    end
    else
    begin
      trig_s1 <= trigger;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      match_s1 <= compare_match;
      match_s2 <= match_s1;
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      act_pkg::ACT_IDLE:
      begin
        if (converter_on && trig_s2 && !trig_s3)
        begin
          next_state = act_pkg::ACT_CONV;
        end
      end
      act_pkg::ACT_CONV:
      begin
        next_state = act_pkg::ACT_WAIT;
      end
      act_pkg::ACT_WAIT:
      begin
        if (!cif.busy)
        begin
          next_state = act_pkg::ACT_IDLE;
        end
      end
      default:
      begin
        next_state = act_pkg::ACT_IDLE;
      end
    endcase
    if (!converter_on)
    begin
      next_state = act_pkg::ACT_IDLE;
    end
  end

  assign cif.start = state == act_pkg::ACT_CONV;
  assign cif.abort = !converter_on;

  // Interrupt event selection: threshold mode replaces the sample count.
  always_comb
  begin
    irq_event = 1'b0;
    next_count = count;
    next_matched = matched;
    next_half = half;
    if (cif.done && match_s2)
    begin
      next_matched = 1'b1;
    end
    if (threshold_detect_enable)
    begin
      unique case (threshold_irq_mode)
        act_pkg::ACT_TIM_SCAN_END: irq_event = cif.eos;
        act_pkg::ACT_TIM_SCAN_MATCH: irq_event = cif.eos && next_matched;
        act_pkg::ACT_TIM_MATCH: irq_event = cif.done && match_s2;
        act_pkg::ACT_TIM_NONE: irq_event = 1'b0;
      endcase
      if (cif.eos)
      begin
        next_matched = 1'b0;
      end
    end
    else if (cif.done)
    begin
      if (count == samples_per_irq)
      begin
        irq_event = 1'b1;
        next_count = 5'h00;
        next_half = ctrl2[act_pkg::CTRL2_BUFFER_FILL_MODE] ? !half : 1'b0;
      end
      else
      begin
        next_count = count + 5'h01;
      end
    end
    if (!converter_on)
    begin
      irq_event = 1'b0;
      next_count = 5'h00;
      next_matched = 1'b0;
    end
  end

  assign clear_flag = wr && addr == act_pkg::ADDR_STATUS && wdata[act_pkg::STAT_FLAG];

  always_comb
  begin
    next_ctrl1 = ctrl1;
    next_ctrl2 = ctrl2;
    next_timing = timing;
    next_thresh = thresh;
    next_scan = scan;
    next_flag = flag;
    if (wr)
    begin
      unique case (addr)
        act_pkg::ADDR_CTRL1: next_ctrl1 = wdata;
        act_pkg::ADDR_CTRL2: next_ctrl2 = wdata;
        act_pkg::ADDR_TIMING: next_timing = wdata;
        act_pkg::ADDR_THRESH: next_thresh = wdata;
        act_pkg::ADDR_SCAN: next_scan = wdata;
        default: next_ctrl1 = ctrl1;
      endcase
    end
    if (clear_flag)
    begin
      next_flag = 1'b0;
    end
    if (irq_event)
    begin
      next_flag = 1'b1;
    end
  end

  always_comb
  begin
    next_rdata = 16'h0000;
    if (rd)
    begin
      unique case (addr)
        act_pkg::ADDR_CTRL1: next_rdata = ctrl1;
        act_pkg::ADDR_CTRL2: next_rdata = ctrl2;
        act_pkg::ADDR_TIMING: next_rdata = timing;
        act_pkg::ADDR_THRESH: next_rdata = thresh;
        act_pkg::ADDR_SCAN: next_rdata = scan;
        act_pkg::ADDR_STATUS: next_rdata = {13'h0000, half, cif.busy, flag};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl1 <= act_pkg::RESET_WORD;
      ctrl2 <= act_pkg::RESET_WORD;
      timing <= act_pkg::RESET_WORD;
      thresh <= act_pkg::RESET_WORD;
      scan <= act_pkg::RESET_WORD;
      flag <= 1'b0;
      matched <= 1'b0;
      half <= 1'b0;
      count <= 5'h00;
      rdata <= 16'h0000;
      state <= act_pkg::ACT_IDLE;
    end
    else
    begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      timing <= next_timing;
      thresh <= next_thresh;
      scan <= next_scan;
      flag <= next_flag;
      matched <= next_matched;
      half <= next_half;
      count <= next_count;
      rdata <= next_rdata;
      state <= next_state;
    end
  end

  assign irq = flag;

  sequence s_eos_scan;
    cif.eos && threshold_detect_enable && threshold_irq_mode == act_pkg::ACT_TIM_SCAN_END;
  endsequence

  sequence s_flag_up;
    ##1 flag;
  endsequence

  a_res_twelve: assert property (@(posedge clk) disable iff (!rstn)
    ctrl1[act_pkg::CTRL1_RES] |-> result_bits == 4'(act_pkg::RES_HI))
    else $error("Resolution select does not give 12 bits.");
  a_pref_onehot: assert property (@(posedge clk) disable iff (!rstn)
    pos_ref_select == act_pkg::PREF_BANDGAP |-> pos_ref_bandgap && !pos_ref_supply && !pos_ref_ext)
    else $error("Band gap reference not selected alone.");
  a_nref_follow: assert property (@(posedge clk) disable iff (!rstn)
    neg_ref_ext == ctrl2[act_pkg::CTRL2_NREF])
    else $error("Negative reference does not follow its bit.");
  a_ref_field: assert property (@(posedge clk) disable iff (!rstn)
    wr && addr == act_pkg::ADDR_CTRL2 |=> pos_ref_select == $past(wdata[act_pkg::CTRL2_PREF_LSB +: 2]))
    else $error("Reference field not taken from bits 15:14.");
  a_scan_end_irq: assert property (@(posedge clk) disable iff (!rstn)
    converter_on ##0 s_eos_scan |-> s_flag_up)
    else $error("Scan end did not set the flag.");
  a_match_irq: assert property (@(posedge clk) disable iff (!rstn)
    converter_on && threshold_detect_enable && threshold_irq_mode == act_pkg::ACT_TIM_MATCH
    && cif.done && match_s2 |=> flag)
    else $error("Immediate match did not set the flag.");
  a_mode_none: assert property (@(posedge clk) disable iff (!rstn)
    threshold_detect_enable && threshold_irq_mode == act_pkg::ACT_TIM_NONE && !flag
    && !clear_flag |=> !flag)
    else $error("Flag set while threshold mode is none.");
  a_off_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !converter_on |=> state == act_pkg::ACT_IDLE && !cif.start)
    else $error("Conversion started while module is off.");
  a_off_no_start: assert property (@(posedge clk) disable iff (!rstn)
    !converter_on |-> !core_start)
    else $error("Core start raised while module is off.");
endmodule // act_ctrl

// File: rtl/act_pkg.sv
// Package with the constants and types of the converter control block.
package act_pkg;
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h1;
  localparam logic [3:0] ADDR_TIMING = 4'h2;
  localparam logic [3:0] ADDR_THRESH = 4'h3;
  localparam logic [3:0] ADDR_SCAN = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam int CTRL1_ON = 15;
  localparam int CTRL1_RES = 11;
  localparam int CTRL1_TRIG_LSB = 4;
  localparam int CTRL2_PREF_LSB = 14;
  localparam int CTRL2_NREF = 13;
  localparam int CTRL2_BUFIDX = 11;
  localparam int CTRL2_BUFFER_FILL_MODE = 1;
  localparam int CTRL2_ALTERNATE_INPUT_SELECT = 0;
  localparam int CTRL2_SAMPLES_PER_IRQ_LSB = 2;
  localparam int THR_EN = 15;
  localparam int THR_MODE_LSB = 8;
  localparam int STAT_FLAG = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_HALF = 2;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int RES_HI = 12;
  localparam int RES_LO = 10;
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_EXT = 2'h1;
  localparam logic [1:0] PREF_BANDGAP = 2'h2;
  typedef enum logic [1:0] {
    ACT_TIM_SCAN_END = 2'h0,
    ACT_TIM_SCAN_MATCH = 2'h1,
    ACT_TIM_MATCH = 2'h2,
    ACT_TIM_NONE = 2'h3
  } act_tim_t;
  typedef enum logic [2:0] {
    ACT_IDLE = 3'b001,
    ACT_CONV = 3'b010,
    ACT_WAIT = 3'b100
  } act_state_t;
endpackage : act_pkg

// File: rtl/act_core_if.sv
// Interface between the control logic and the conversion sequencer.
interface act_core_if;
  logic start;
  logic busy;
  logic done;
  logic eos;
  logic abort;
  modport ctrl (output start, output abort, input busy, input done, input eos);
  modport seq (input start, input abort, output busy, output done, output eos);
endinterface : act_core_if

// File: rtl/act_seq.sv
// Sequencer that hands conversions to the analog core.
module act_seq
(
  input wire logic clk,
  input wire logic rstn,
  act_core_if.seq cif,
  input wire logic [15:0] scan_mask,
  input wire logic core_done_pin,
  output logic core_start,
  output logic [4:0] core_channel
);
  logic [3:0] chan;
  logic [3:0] next_chan;
  logic busy;
  logic next_busy;
  logic [15:0] remain;
  logic [15:0] next_remain;
  logic start_q;
  logic next_start_q;
  logic done_s1;
  logic done_s2;
  logic done_s3;
  logic step;
  logic last;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end
    else
    begin
      done_s1 <= core_done_pin;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  assign step = busy && done_s2 && !done_s3;
  assign last = (remain & ~(16'h0001 << chan)) == 16'h0000;

  always_comb
  begin
    next_chan = chan;
    next_busy = busy;
    next_remain = remain;
    next_start_q = 1'b0;
    if (!busy && cif.start)
    begin
      next_busy = 1'b1;
      next_remain = (scan_mask == 16'h0000) ? 16'h0001 : scan_mask;
      next_chan = 4'h0;
      next_start_q = 1'b1;
    end
    else if (step)
    begin
      next_remain = remain & ~(16'h0001 << chan);
      if (last)
      begin
        next_busy = 1'b0;
      end
      else
      begin
        next_chan = chan + 4'h1;
        next_start_q = 1'b1;
      end
    end
    else if (busy && !remain[chan] && !start_q)
    begin
      next_chan = chan + 4'h1;
      next_start_q = remain[chan + 4'h1];
    end
    // Dropping the module enable ends any scan in flight.
    if (cif.abort)
    begin
      next_busy = 1'b0;
      next_start_q = 1'b0;
      next_remain = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chan <= 4'h0;
      busy <= 1'b0;
      remain <= 16'h0000;
      start_q <= 1'b0;
    end
    else
    begin
      chan <= next_chan;
      busy <= next_busy;
      remain <= next_remain;
      start_q <= next_start_q;
    end
  end

  assign core_start = start_q && remain[chan] && !cif.abort;
  assign core_channel = {1'b0, chan};
  assign cif.busy = busy;
  assign cif.done = step;
  assign cif.eos = step && last;
endmodule // act_seq

// File: test/act_core_model.sv
// Behavioural model of the analog conversion core and input multiplexer.
module act_core_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic core_start,
  input wire logic [4:0] core_channel,
  input wire logic slow,
  input wire logic [4:0] match_channel,
  input wire logic match_en,
  output logic core_done,
  output logic compare_match
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Any channel is converted, the shared reference pins included.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 0;
      core_done <= 1'b0;
      compare_match <= 1'b0;
    end
    else if (core_start)
    begin
      cnt <= slow ? 12 : 6;
      core_done <= 1'b0;
      compare_match <= match_en && (core_channel == match_channel);
    end
    else
    begin
      cnt <= (cnt > 0) ? cnt - 1 : 0;
      core_done <= (cnt >= 1) && (cnt <= 3);
    end
  end
endmodule // act_core_model

// File: test/testbench.sv
// Self-checking testbench of the converter control block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wr, rd, trigger, compare_match, core_done, core_start;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [4:0] core_channel;
  logic [3:0] result_bits;
  logic pos_ref_supply, pos_ref_ext, pos_ref_bandgap, neg_ref_ext, irq, slow, match_en;
  logic [15:0] chan_seen;
  int n_starts;
  int fail_count;
  int tests_run;

  act_ctrl dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trigger(trigger), .compare_match(compare_match), .core_done(core_done),
    .core_start(core_start), .core_channel(core_channel), .result_bits(result_bits),
    .pos_ref_supply(pos_ref_supply), .pos_ref_ext(pos_ref_ext),
    .pos_ref_bandgap(pos_ref_bandgap), .neg_ref_ext(neg_ref_ext), .irq(irq));

  act_core_model core_u (.clk(clk), .rstn(rstn), .core_start(core_start),
    .core_channel(core_channel), .slow(slow), .match_channel(5'h00), .match_en(match_en),
    .core_done(core_done), .compare_match(compare_match));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (core_start === 1'b1)
    begin
      n_starts++;
      chan_seen[core_channel[3:0]] = 1'b1;
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_idle();
    logic [15:0] d;
    bit seen;
    seen = 0;
    for (int i = 0; i < 300; i++)
    begin
      rd_reg(act_pkg::ADDR_STATUS, d);
      if (d[act_pkg::STAT_DONE] === 1'b1)
        seen = 1;
      else if (seen)
        return;
    end
    fail_count++;
    $display("Error busy expected idle seen stuck");
    complete_run();
  endtask

  task automatic t_reset();
    logic [15:0] d;
    rd_reg(act_pkg::ADDR_CTRL1, d);
    chk("ctrl1", act_pkg::RESET_WORD, d);
    rd_reg(act_pkg::ADDR_CTRL2, d);
    chk("ctrl2", act_pkg::RESET_WORD, d);
    rd_reg(act_pkg::ADDR_THRESH, d);
    chk("threshold", act_pkg::RESET_WORD, d);
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, d);
    chk("unmapped", 16'h0000, d);
    rd_reg(act_pkg::ADDR_CTRL1, d);
    chk("ctrl1 after unmapped", 16'h0000, d);
    chk("irq", 16'h0000, {15'h0000, irq});
  endtask

  task automatic t_resolution();
    wr_reg(act_pkg::ADDR_CTRL1, 16'h0800);
    #1;
    chk("result_bits", 16'h000C, {12'h000, result_bits});
    wr_reg(act_pkg::ADDR_CTRL1, 16'h0000);
    #1;
    chk("result_bits", 16'h000A, {12'h000, result_bits});
  endtask

  task automatic t_refs();
    for (int p = 0; p < 3; p++)
    begin
      for (int n = 0; n < 2; n++)
      begin
        wr_reg(act_pkg::ADDR_CTRL2, {p[1:0], n[0], 13'h0000});
        #1;
        chk("pos_ref", 16'h0004 >> p, {13'h0000, pos_ref_supply, pos_ref_ext, pos_ref_bandgap});
        chk("neg_ref", {15'h0000, n[0]}, {15'h0000, neg_ref_ext});
      end
    end
  endtask

  task automatic t_off();
    wr_reg(act_pkg::ADDR_THRESH, 16'h8000);
    n_starts = 0;
    trigger <= 1'b1;
    repeat (4) @(posedge clk);
    trigger <= 1'b0;
    repeat (30) @(posedge clk);
    chk("starts while off", 16'h0000, n_starts[15:0]);
    chk("irq while off", 16'h0000, {15'h0000, irq});
  endtask

  task automatic t_abort();
    logic [15:0] d;
    wr_reg(act_pkg::ADDR_SCAN, 16'hFFFF);
    wr_reg(act_pkg::ADDR_THRESH, 16'h8000);
    wr_reg(act_pkg::ADDR_CTRL1, 16'h8000);
    trigger <= 1'b1;
    repeat (20) @(posedge clk);
    trigger <= 1'b0;
    wr_reg(act_pkg::ADDR_CTRL1, 16'h0000);
    @(posedge clk);
    n_starts = 0;
    repeat (40) @(posedge clk);
    rd_reg(act_pkg::ADDR_STATUS, d);
    chk("starts after off", 16'h0000, n_starts[15:0]);
    chk("status after off", 16'h0000, d);
  endtask

  task automatic run_case(input logic [15:0] thr, input logic [15:0] refs,
    input logic [15:0] mask, input logic men, input logic exp_irq);
    wr_reg(act_pkg::ADDR_CTRL1, 16'h0000);
    wr_reg(act_pkg::ADDR_CTRL2, refs | 16'h0800);
    wr_reg(act_pkg::ADDR_SCAN, mask);
    wr_reg(act_pkg::ADDR_THRESH, thr);
    wr_reg(act_pkg::ADDR_STATUS, 16'h0001);
    match_en <= men;
    slow <= ~slow;
    n_starts = 0;
    chan_seen = 16'h0000;
    wr_reg(act_pkg::ADDR_CTRL1, 16'h8000);
    trigger <= 1'b1;
    repeat (4) @(posedge clk);
    trigger <= 1'b0;
    wait_idle();
    repeat (3) @(posedge clk);
    #1;
    chk("irq", {15'h0000, exp_irq}, {15'h0000, irq});
    chk("channels", mask, chan_seen);
    wr_reg(act_pkg::ADDR_STATUS, 16'h0001);
    #1;
    chk("irq cleared", 16'h0000, {15'h0000, irq});
  endtask

  task automatic t_threshold();
    run_case(16'h8000, 16'h0000, 16'h0003, 1'b0, 1'b1);
    run_case(16'h8100, 16'h0000, 16'h0003, 1'b0, 1'b0);
    run_case(16'h8100, 16'h0000, 16'h0003, 1'b1, 1'b1);
    run_case(16'h8200, 16'h0000, 16'h0003, 1'b0, 1'b0);
    run_case(16'h8200, 16'h0000, 16'h0003, 1'b1, 1'b1);
    run_case(16'h8300, 16'h0000, 16'h0003, 1'b1, 1'b0);
    run_case(16'h0000, 16'h0014, 16'h0003, 1'b1, 1'b0);
    run_case(16'h0000, 16'h0004, 16'h0003, 1'b0, 1'b1);
    run_case(16'h8000, 16'h6000, 16'h000C, 1'b0, 1'b1);
  endtask

  initial
  begin
    rstn = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    trigger = 1'b0;
    slow = 1'b0;
    match_en = 1'b0;
    chan_seen = 16'h0000;
    n_starts = 0;
    fail_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_resolution();
    t_refs();
    t_off();
    t_abort();
    t_threshold();
    complete_run();
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    fail_count++;
    $display("Error run expected end seen timeout");
    complete_run();
  end
endmodule // testbench
